/* design/compander_segment_params.sv */
// compander curve parameter registers with the curve mapper behind them
//
// Contract
// - segment two base is 10 bits, its low byte is read/write at 35h, reset BFh.
// - segment three base is 10 bits, its low byte is read/write at 36h, reset 05h.
// - segment four base is 10 bits, its low byte is read/write at 37h, reset 20h.
// - segment one end is 13 bits, its low byte is read/write at 39h.
// - segment two end is 13 bits, its low byte is read/write at 3Bh, reset 18h.
// - bits 4:0 of 38h hold the top five bits of segment one end, reset 03h, bits 7:5 reserved.
// - bits 4:0 of 3Ah hold the top five bits of segment two end, reset 05h, bits 7:5 reserved.
// - the top two bits of bases two, three and four come from bit pairs of 34h.
// - with linear mapping off, the first offset is the black level of the curve.
// - segment three end is 13 bits split over a high and low byte like the others.
`timescale 1ns/100ps
module compander_segment_params (
   input  wire logic                  mclk,
   input  wire logic                  reset,
   input  wire logic [7:0]            regAddr,
   input  wire logic [7:0]            regWrData,
   input  wire logic                  regWrEn,
   input  wire logic                  regRdEn,
   input  wire logic [12:0]           sampleIn,
   input  wire logic                  sampleValid,
   input  wire logic                  compLinear,
   input  wire logic [8:0]            slopeOne,
   input  wire logic [8:0]            slopeTwo,
   input  wire logic [8:0]            slopeThree,
   input  wire logic [8:0]            slopeFour,
   output logic [7:0]                 regRdData_ff,
   output logic                       regRdValid_ff,
   output logic [7:0]                 curveBlackLevel,
   output logic [9:0]                 segmentTwoBase,
   output logic [9:0]                 segmentThreeBase,
   output logic [9:0]                 segmentFourBase,
   output logic [12:0]                segmentOneEnd,
   output logic [12:0]                segmentTwoEnd,
   output logic [12:0]                segmentThreeEnd,
   output logic [9:0]                 curveOut_ff,
   output logic                       curveValid_ff,
   output compander_pkg::segment_e    curveSegment_ff
);
   logic [7:0]  blackLevel_ff;
   logic [7:0]  baseHigh_ff;
   logic [7:0]  seg2BaseLow_ff;
   logic [7:0]  seg3BaseLow_ff;
   logic [7:0]  seg4BaseLow_ff;
   logic [7:0]  seg1EndHigh_ff;
   logic [7:0]  seg1EndLow_ff;
   logic [7:0]  seg2EndHigh_ff;
   logic [7:0]  seg2EndLow_ff;
   logic [7:0]  seg3EndHigh_ff;
   logic [7:0]  seg3EndLow_ff;

   logic [7:0]  nxt_blackLevel;
   logic [7:0]  nxt_baseHigh;
   logic [7:0]  nxt_seg2BaseLow;
   logic [7:0]  nxt_seg3BaseLow;
   logic [7:0]  nxt_seg4BaseLow;
   logic [7:0]  nxt_seg1EndHigh;
   logic [7:0]  nxt_seg1EndLow;
   logic [7:0]  nxt_seg2EndHigh;
   logic [7:0]  nxt_seg2EndLow;
   logic [7:0]  nxt_seg3EndHigh;
   logic [7:0]  nxt_seg3EndLow;
   logic [7:0]  readMux;
   logic [7:0]  nxt_regRdData;

   function automatic logic wrHit(input logic [7:0] addr,
                                  input logic       en,
                                  input logic [7:0] target);
      wrHit = en && (addr == target);
   endfunction

   // reserved bits are masked on the way in, so they always read zero
   function automatic logic [7:0] readSelect(input logic [7:0] addr,
                                             input logic [7:0] blk,
                                             input logic [7:0] bh,
                                             input logic [7:0] b2,
                                             input logic [7:0] b3,
                                             input logic [7:0] b4,
                                             input logic [7:0] e1h,
                                             input logic [7:0] e1l,
                                             input logic [7:0] e2h,
                                             input logic [7:0] e2l,
                                             input logic [7:0] e3h,
                                             input logic [7:0] e3l);
      case (addr)
         compander_pkg::ADDR_BLACK_LEVEL:   readSelect = blk;
         compander_pkg::ADDR_BASE_HIGH:     readSelect = bh;
         compander_pkg::ADDR_SEG2_BASE_LOW: readSelect = b2;
         compander_pkg::ADDR_SEG3_BASE_LOW: readSelect = b3;
         compander_pkg::ADDR_SEG4_BASE_LOW: readSelect = b4;
         compander_pkg::ADDR_SEG1_END_HIGH: readSelect = e1h;
         compander_pkg::ADDR_SEG1_END_LOW:  readSelect = e1l;
         compander_pkg::ADDR_SEG2_END_HIGH: readSelect = e2h;
         compander_pkg::ADDR_SEG2_END_LOW:  readSelect = e2l;
         compander_pkg::ADDR_SEG3_END_HIGH: readSelect = e3h;
         compander_pkg::ADDR_SEG3_END_LOW:  readSelect = e3l;
         default:                           readSelect = compander_pkg::READ_IDLE;
      endcase
   endfunction

   assign nxt_blackLevel  = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_BLACK_LEVEL) ? regWrData : blackLevel_ff;
   assign nxt_baseHigh    = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_BASE_HIGH) ?
      (regWrData & compander_pkg::BASE_HIGH_MASK) : baseHigh_ff;
   assign nxt_seg2BaseLow = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_SEG2_BASE_LOW) ? regWrData : seg2BaseLow_ff;
   assign nxt_seg3BaseLow = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_SEG3_BASE_LOW) ? regWrData : seg3BaseLow_ff;
   assign nxt_seg4BaseLow = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_SEG4_BASE_LOW) ? regWrData : seg4BaseLow_ff;
   assign nxt_seg1EndHigh = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_SEG1_END_HIGH) ?
      (regWrData & compander_pkg::END_HIGH_MASK) : seg1EndHigh_ff;
   assign nxt_seg1EndLow  = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_SEG1_END_LOW) ? regWrData : seg1EndLow_ff;
   assign nxt_seg2EndHigh = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_SEG2_END_HIGH) ?
      (regWrData & compander_pkg::END_HIGH_MASK) : seg2EndHigh_ff;
   assign nxt_seg2EndLow  = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_SEG2_END_LOW) ? regWrData : seg2EndLow_ff;
   assign nxt_seg3EndHigh = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_SEG3_END_HIGH) ?
      (regWrData & compander_pkg::END_HIGH_MASK) : seg3EndHigh_ff;
   assign nxt_seg3EndLow  = wrHit(regAddr, regWrEn,
      compander_pkg::ADDR_SEG3_END_LOW) ? regWrData : seg3EndLow_ff;

   always_ff @(posedge mclk) begin
      if (reset) begin
         blackLevel_ff  <= compander_pkg::RST_BLACK_LEVEL;
         baseHigh_ff    <= compander_pkg::RST_BASE_HIGH;
         seg2BaseLow_ff <= compander_pkg::RST_SEG2_BASE_LOW;
         seg3BaseLow_ff <= compander_pkg::RST_SEG3_BASE_LOW;
         seg4BaseLow_ff <= compander_pkg::RST_SEG4_BASE_LOW;
         seg1EndHigh_ff <= compander_pkg::RST_SEG1_END_HIGH;
         seg1EndLow_ff  <= compander_pkg::RST_SEG1_END_LOW;
         seg2EndHigh_ff <= compander_pkg::RST_SEG2_END_HIGH;
         seg2EndLow_ff  <= compander_pkg::RST_SEG2_END_LOW;
         seg3EndHigh_ff <= compander_pkg::RST_SEG3_END_HIGH;
         seg3EndLow_ff  <= compander_pkg::RST_SEG3_END_LOW;
      end else begin
         blackLevel_ff  <= nxt_blackLevel;
         baseHigh_ff    <= nxt_baseHigh;
         seg2BaseLow_ff <= nxt_seg2BaseLow;
         seg3BaseLow_ff <= nxt_seg3BaseLow;
         seg4BaseLow_ff <= nxt_seg4BaseLow;
         seg1EndHigh_ff <= nxt_seg1EndHigh;
         seg1EndLow_ff  <= nxt_seg1EndLow;
         seg2EndHigh_ff <= nxt_seg2EndHigh;
         seg2EndLow_ff  <= nxt_seg2EndLow;
         seg3EndHigh_ff <= nxt_seg3EndHigh;
         seg3EndLow_ff  <= nxt_seg3EndLow;
      end
   end

   // a read in the same cycle as a write returns the old value
   assign readMux = readSelect(regAddr, blackLevel_ff, baseHigh_ff,
                               seg2BaseLow_ff, seg3BaseLow_ff,
                               seg4BaseLow_ff, seg1EndHigh_ff,
                               seg1EndLow_ff, seg2EndHigh_ff,
                               seg2EndLow_ff, seg3EndHigh_ff,
                               seg3EndLow_ff);
   assign nxt_regRdData = regRdEn ? readMux : regRdData_ff;

   always_ff @(posedge mclk) begin
      if (reset) begin
         regRdData_ff  <= compander_pkg::READ_IDLE;
         regRdValid_ff <= 1'b0;
      end else begin
         regRdData_ff  <= nxt_regRdData;
         regRdValid_ff <= regRdEn;
      end
   end

   // assembled values are plain concatenations of register bits
   assign curveBlackLevel  = blackLevel_ff;
   assign segmentTwoBase   = {baseHigh_ff[compander_pkg::SEG2_HIGH_LSB +:
                             compander_pkg::HIGH_W], seg2BaseLow_ff};
   assign segmentThreeBase = {baseHigh_ff[compander_pkg::SEG3_HIGH_LSB +:
                             compander_pkg::HIGH_W], seg3BaseLow_ff};
   assign segmentFourBase  = {baseHigh_ff[compander_pkg::SEG4_HIGH_LSB +:
                             compander_pkg::HIGH_W], seg4BaseLow_ff};
   assign segmentOneEnd    = {seg1EndHigh_ff[compander_pkg::END_HIGH_W-1:0],
                             seg1EndLow_ff};
   assign segmentTwoEnd    = {seg2EndHigh_ff[compander_pkg::END_HIGH_W-1:0],
                             seg2EndLow_ff};
   assign segmentThreeEnd  = {seg3EndHigh_ff[compander_pkg::END_HIGH_W-1:0],
                             seg3EndLow_ff};

   compander_curve curve (
      .mclk          (mclk),
      .reset         (reset),
      .sampleIn      (sampleIn),
      .sampleValid   (sampleValid),
      .compLinear    (compLinear),
      .blackLevel    (blackLevel_ff),
      .segTwoBase    (segmentTwoBase),
      .segThreeBase  (segmentThreeBase),
      .segFourBase   (segmentFourBase),
      .segOneEnd     (segmentOneEnd),
      .segTwoEnd     (segmentTwoEnd),
      .segThreeEnd   (segmentThreeEnd),
      .slopeOne      (slopeOne),
      .slopeTwo      (slopeTwo),
      .slopeThree    (slopeThree),
      .slopeFour     (slopeFour),
      .curveOut_ff   (curveOut_ff),
      .curveValid_ff (curveValid_ff),
      .segment_ff    (curveSegment_ff)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence wrTo(logic [7:0] target);
      regWrEn && regAddr == target;
   endsequence

   sequence rdFrom(logic [7:0] target);
      regRdEn && !regWrEn && regAddr == target;
   endsequence

   a_seg2_low_write: assert property (
      wrTo(compander_pkg::ADDR_SEG2_BASE_LOW)
      |=> segmentTwoBase[7:0] == $past(regWrData))
      else $error("segment two base low byte not stored");
   a_seg3_low_write: assert property (
      wrTo(compander_pkg::ADDR_SEG3_BASE_LOW) ##1 rdFrom(
      compander_pkg::ADDR_SEG3_BASE_LOW)
      |=> regRdData_ff == $past(regWrData, 2) && regRdValid_ff)
      else $error("segment three base low byte read back wrong");
   a_seg4_low_write: assert property (
      wrTo(compander_pkg::ADDR_SEG4_BASE_LOW)
      |=> segmentFourBase[7:0] == $past(regWrData))
      else $error("segment four base low byte not stored");
   a_end1_low_write: assert property (
      wrTo(compander_pkg::ADDR_SEG1_END_LOW)
      |=> segmentOneEnd[7:0] == $past(regWrData)
          && segmentOneEnd[12:8] == $past(segmentOneEnd[12:8]))
      else $error("segment one end low byte not stored");
   a_end2_reset: assert property (
      $past(reset) |-> segmentTwoEnd == 13'h0518)
      else $error("segment two end reset value wrong");
   a_end1_high_read: assert property (
      wrTo(compander_pkg::ADDR_SEG1_END_HIGH) ##1 rdFrom(
      compander_pkg::ADDR_SEG1_END_HIGH)
      |=> regRdData_ff == {3'b000, $past(regWrData[4:0], 2)})
      else $error("segment one end high byte read back wrong");
   a_end2_high_write: assert property (
      wrTo(compander_pkg::ADDR_SEG2_END_HIGH)
      |=> segmentTwoEnd[12:8] == $past(regWrData[4:0]))
      else $error("segment two end high bits not stored");
   a_base_high_split: assert property (
      wrTo(compander_pkg::ADDR_BASE_HIGH)
      |=> segmentTwoBase[9:8] == $past(regWrData[5:4])
          && segmentThreeBase[9:8] == $past(regWrData[3:2])
          && segmentFourBase[9:8] == $past(regWrData[1:0]))
      else $error("base high bit pairs misplaced");
   a_black_write: assert property (
      wrTo(compander_pkg::ADDR_BLACK_LEVEL)
      |=> curveBlackLevel == $past(regWrData))
      else $error("black level not stored");
   a_end3_write: assert property (
      wrTo(compander_pkg::ADDR_SEG3_END_HIGH) ##1
      wrTo(compander_pkg::ADDR_SEG3_END_LOW)
      |=> segmentThreeEnd == {$past(regWrData[4:0], 2), $past(regWrData)})
      else $error("segment three end not assembled");
   a_curve_latency: assert property (
      sampleValid |=> curveValid_ff)
      else $error("curve result missing");
   a_read_pulse: assert property (
      regRdEn |=> regRdValid_ff)
      else $error("read answer missing");
   a_read_unmapped: assert property (
      regRdEn && regAddr > compander_pkg::ADDR_SEG3_END_LOW
      |=> regRdData_ff == compander_pkg::READ_IDLE)
      else $error("unmapped read not zero");
   a_seg2_reset: assert property (
      $past(reset) |-> segmentTwoBase[7:0] == compander_pkg::RST_SEG2_BASE_LOW)
      else $error("segment two base reset value wrong");
   a_seg3_reset: assert property (
      $past(reset) |-> segmentThreeBase[7:0] == compander_pkg::RST_SEG3_BASE_LOW)
      else $error("segment three base reset value wrong");
   a_seg4_reset: assert property (
      $past(reset) |-> segmentFourBase[7:0] == compander_pkg::RST_SEG4_BASE_LOW)
      else $error("segment four base reset value wrong");
   a_end1_reset: assert property (
      $past(reset) |-> segmentOneEnd[12:8]
          == compander_pkg::RST_SEG1_END_HIGH[4:0])
      else $error("segment one end reset value wrong");
   a_end1_reserved: assert property (
      wrTo(compander_pkg::ADDR_SEG1_END_HIGH)
      |=> seg1EndHigh_ff[7:5] == 3'b000)
      else $error("segment one end reserved bits stored");
   a_end2_reserved: assert property (
      wrTo(compander_pkg::ADDR_SEG2_END_HIGH)
      |=> seg2EndHigh_ff[7:5] == 3'b000)
      else $error("segment two end reserved bits stored");
   a_base_reserved: assert property (
      wrTo(compander_pkg::ADDR_BASE_HIGH)
      |=> baseHigh_ff[7:6] == 2'b00)
      else $error("base high reserved bits stored");

endmodule // compander_segment_params

/* design/compander_pkg.sv */
// constants, field layout and types for the compander curve parameter bank
package compander_pkg;

   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 8;
   localparam int BASE_W  = 10;
   localparam int END_W   = 13;
   localparam int SLOPE_W = 9;
   localparam int HIGH_W  = 2;

   localparam logic [7:0] ADDR_BLACK_LEVEL   = 8'h33;
   localparam logic [7:0] ADDR_BASE_HIGH     = 8'h34;
   localparam logic [7:0] ADDR_SEG2_BASE_LOW = 8'h35;
   localparam logic [7:0] ADDR_SEG3_BASE_LOW = 8'h36;
   localparam logic [7:0] ADDR_SEG4_BASE_LOW = 8'h37;
   localparam logic [7:0] ADDR_SEG1_END_HIGH = 8'h38;
   localparam logic [7:0] ADDR_SEG1_END_LOW  = 8'h39;
   localparam logic [7:0] ADDR_SEG2_END_HIGH = 8'h3A;
   localparam logic [7:0] ADDR_SEG2_END_LOW  = 8'h3B;
   localparam logic [7:0] ADDR_SEG3_END_HIGH = 8'h3C;
   localparam logic [7:0] ADDR_SEG3_END_LOW  = 8'h3D;

   localparam logic [7:0] RST_BLACK_LEVEL   = 8'h08;
   localparam logic [7:0] RST_BASE_HIGH     = 8'h0B;
   localparam logic [7:0] RST_SEG2_BASE_LOW = 8'hBF;
   localparam logic [7:0] RST_SEG3_BASE_LOW = 8'h05;
   localparam logic [7:0] RST_SEG4_BASE_LOW = 8'h20;
   localparam logic [7:0] RST_SEG1_END_HIGH = 8'h03;
   localparam logic [7:0] RST_SEG1_END_LOW  = 8'h20;
   localparam logic [7:0] RST_SEG2_END_HIGH = 8'h05;
   localparam logic [7:0] RST_SEG2_END_LOW  = 8'h18;
   localparam logic [7:0] RST_SEG3_END_HIGH = 8'h0B;
   localparam logic [7:0] RST_SEG3_END_LOW  = 8'h58;

   // writable bits; reserved bits store nothing and read as zero
   localparam logic [7:0] BASE_HIGH_MASK = 8'h3F;
   localparam logic [7:0] END_HIGH_MASK  = 8'h1F;
   localparam logic [7:0] READ_IDLE      = 8'h00;

   localparam int SEG2_HIGH_LSB = 4;
   localparam int SEG3_HIGH_LSB = 2;
   localparam int SEG4_HIGH_LSB = 0;
   localparam int END_HIGH_W    = 5;

   // slope has 8 fraction bits; linear mode drops 3 bits of the sample
   localparam int SLOPE_FRAC   = 8;
   localparam int LINEAR_SHIFT = 3;
   localparam logic [9:0] OUT_MAX = 10'h3FF;

   localparam int READ_LATENCY  = 1;
   localparam int CURVE_LATENCY = 1;

   typedef enum logic [1:0] {SEG_ONE, SEG_TWO, SEG_THREE, SEG_FOUR} segment_e;

endpackage

/* design/compander_curve.sv */
// segment selection and offset-plus-slope mapping of 13-bit samples
`timescale 1ns/100ps
module compander_curve (
   input  wire logic                  mclk,
   input  wire logic                  reset,
   input  wire logic [12:0]           sampleIn,
   input  wire logic                  sampleValid,
   input  wire logic                  compLinear,
   input  wire logic [7:0]            blackLevel,
   input  wire logic [9:0]            segTwoBase,
   input  wire logic [9:0]            segThreeBase,
   input  wire logic [9:0]            segFourBase,
   input  wire logic [12:0]           segOneEnd,
   input  wire logic [12:0]           segTwoEnd,
   input  wire logic [12:0]           segThreeEnd,
   input  wire logic [8:0]            slopeOne,
   input  wire logic [8:0]            slopeTwo,
   input  wire logic [8:0]            slopeThree,
   input  wire logic [8:0]            slopeFour,
   output logic [9:0]                 curveOut_ff,
   output logic                       curveValid_ff,
   output compander_pkg::segment_e    segment_ff
);
   logic                     inOne;
   logic                     inTwo;
   logic                     inThree;
   compander_pkg::segment_e  segment;
   logic [12:0]              startPoint;
   logic [9:0]               base;
   logic [8:0]               slope;
   logic [12:0]              delta;
   logic [21:0]              product;
   logic [13:0]              scaled;
   logic [14:0]              sum;
   logic [9:0]               mapped;
   logic [9:0]               nxt_curveOut;

   // end points are inclusive upper bounds of each segment
   assign inOne   = sampleIn <= segOneEnd;
   assign inTwo   = sampleIn <= segTwoEnd;
   assign inThree = sampleIn <= segThreeEnd;
   assign segment = inOne ? compander_pkg::SEG_ONE :
                    inTwo ? compander_pkg::SEG_TWO :
                    inThree ? compander_pkg::SEG_THREE :
                    compander_pkg::SEG_FOUR;

   always_comb begin
      case (segment)
         compander_pkg::SEG_ONE: begin
            startPoint = 13'h0000;
            base       = {2'b00, blackLevel};
            slope      = slopeOne;
         end
         compander_pkg::SEG_TWO: begin
            startPoint = segOneEnd;
            base       = segTwoBase;
            slope      = slopeTwo;
         end
         compander_pkg::SEG_THREE: begin
            startPoint = segTwoEnd;
            base       = segThreeBase;
            slope      = slopeThree;
         end
         default: begin
            startPoint = segThreeEnd;
            base       = segFourBase;
            slope      = slopeFour;
         end
      endcase
   end

   assign delta   = sampleIn - startPoint;
   assign product = {13'h0000, slope} * {9'h000, delta};
   assign scaled  = product[21:compander_pkg::SLOPE_FRAC];
   assign sum     = {5'h00, base} + {1'b0, scaled};
   // saturate rather than wrap at the top of the 10-bit range
   assign mapped  = (|sum[14:10]) ? compander_pkg::OUT_MAX : sum[9:0];
   assign nxt_curveOut = compLinear ?
                         sampleIn[12:compander_pkg::LINEAR_SHIFT] : mapped;

   always_ff @(posedge mclk) begin
      if (reset) begin
         curveOut_ff   <= 10'h000;
         curveValid_ff <= 1'b0;
         segment_ff    <= compander_pkg::SEG_ONE;
      end else begin
         curveValid_ff <= sampleValid;
         if (sampleValid) begin
            curveOut_ff <= nxt_curveOut;
            segment_ff  <= segment;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_black_level_use: assert property (
      sampleValid && !compLinear && sampleIn == 13'h0000
      |=> curveOut_ff == {2'b00, $past(blackLevel)})
      else $error("black level not used at zero input");
   a_segment_pick: assert property (
      sampleValid && sampleIn > segOneEnd && sampleIn <= segTwoEnd
      |=> segment_ff == compander_pkg::SEG_TWO)
      else $error("wrong segment chosen");
   a_linear_map: assert property (
      sampleValid && compLinear
      |=> curveOut_ff == $past(sampleIn[12:3]) && curveValid_ff)
      else $error("linear mapping wrong");

endmodule // compander_curve

/* tb/test_compander_segment_params.sv */
// self-checking bench for the compander curve parameter registers
`timescale 1ns/100ps
module test_compander_segment_params;
   logic        mclk, reset, regWrEn, regRdEn, sampleValid, compLinear;
   logic [7:0]  regAddr, regWrData, regRdData_ff, curveBlackLevel;
   logic [12:0] sampleIn, segmentOneEnd, segmentTwoEnd, segmentThreeEnd;
   logic [8:0]  slope, slopeTwo;
   logic [9:0]  segmentTwoBase, segmentThreeBase, segmentFourBase;
   logic [9:0]  curveOut_ff;
   logic        regRdValid_ff, curveValid_ff;
   compander_pkg::segment_e curveSegment_ff;
   int          fails, checked, i;
   logic [7:0]  rstVal [11] = '{8'h08, 8'h0B, 8'hBF, 8'h05, 8'h20, 8'h03,
                                8'h20, 8'h05, 8'h18, 8'h0B, 8'h58};
   logic [7:0]  mask [11]   = '{8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h1F,
                                8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF};
   // black 10h, bases 100h/200h/300h, ends 100h/200h/300h
   logic [7:0]  cfg [11]    = '{8'h10, 8'h1B, 8'h00, 8'h00, 8'h00, 8'h01,
                                8'h00, 8'h02, 8'h00, 8'h03, 8'h00};

   compander_segment_params uut (.mclk(mclk), .reset(reset),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .sampleIn(sampleIn), .sampleValid(sampleValid),
      .compLinear(compLinear), .slopeOne(slope), .slopeTwo(slopeTwo),
      .slopeThree(slope), .slopeFour(slope), .regRdData_ff(regRdData_ff),
      .regRdValid_ff(regRdValid_ff), .curveBlackLevel(curveBlackLevel),
      .segmentTwoBase(segmentTwoBase), .segmentThreeBase(segmentThreeBase),
      .segmentFourBase(segmentFourBase), .segmentOneEnd(segmentOneEnd),
      .segmentTwoEnd(segmentTwoEnd), .segmentThreeEnd(segmentThreeEnd),
      .curveOut_ff(curveOut_ff), .curveValid_ff(curveValid_ff),
      .curveSegment_ff(curveSegment_ff));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic results();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // waits a bounded number of cycles for a one-cycle answer pulse
   task automatic waitPulse(ref logic flag);
      int n;
      n = 0;
      #1;
      while (flag !== 1'b1 && n < 4) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (flag !== 1'b1) begin
         fails++;
         $display("ERROR %0t: answer never came", $time);
         results();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge mclk);
      regWrEn <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge mclk);
      regRdEn <= 1'b0;
      waitPulse(regRdValid_ff);
      chk({5'h00, regRdData_ff}, {5'h00, e});
   endtask

   task automatic smp(input logic [12:0] s, input logic [9:0] e,
                      input logic [1:0] seg);
      @(posedge mclk);
      sampleIn <= s;
      sampleValid <= 1'b1;
      @(posedge mclk);
      sampleValid <= 1'b0;
      waitPulse(curveValid_ff);
      chk({3'h0, curveOut_ff}, {3'h0, e});
      if (compLinear == 1'b0) chk({11'h000, curveSegment_ff}, {11'h000, seg});
   endtask

   initial begin
      {reset, regWrEn, regRdEn, sampleValid, compLinear} = 5'h10;
      {regAddr, regWrData, sampleIn} = 29'h0000_0000;
      slope = 9'h100;
      slopeTwo = 9'h080;
      fails = 0;
      checked = 0;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      for (i = 0; i < 11; i++) rd(8'h33 + i[7:0], rstVal[i]);
      chk({3'h0, segmentTwoBase}, 13'h00BF);
      chk({3'h0, segmentThreeBase}, 13'h0205);
      chk({3'h0, segmentFourBase}, 13'h0320);
      chk(segmentOneEnd, 13'h0320);
      chk(segmentTwoEnd, 13'h0518);
      chk(segmentThreeEnd, 13'h0B58);
      for (i = 0; i < 11; i++) wr(8'h33 + i[7:0], 8'hFF);
      for (i = 0; i < 11; i++) rd(8'h33 + i[7:0], mask[i]);
      chk(segmentOneEnd & segmentTwoEnd & segmentThreeEnd, 13'h1FFF);
      chk({3'h0, segmentTwoBase & segmentThreeBase & segmentFourBase}, 13'h03FF);
      wr(8'h3E, 8'h55);
      rd(8'h3E, 8'h00);
      @(posedge mclk);
      regAddr <= 8'h35;
      regWrData <= 8'h5A;
      {regWrEn, regRdEn} <= 2'b11;
      @(posedge mclk);
      {regWrEn, regRdEn} <= 2'b00;
      waitPulse(regRdValid_ff);
      chk({5'h00, regRdData_ff}, 13'h00FF);
      rd(8'h35, 8'h5A);
      for (i = 0; i < 11; i++) wr(8'h33 + i[7:0], cfg[i]);
      #1;
      chk({5'h00, curveBlackLevel}, 13'h0010);
      chk({3'h0, segmentFourBase}, 13'h0300);
      chk(segmentThreeEnd, 13'h0300);
      smp(13'h0000, 10'h010, 2'd0);
      smp(13'h0080, 10'h090, 2'd0);
      smp(13'h0100, 10'h110, 2'd0);
      smp(13'h0200, 10'h180, 2'd1);
      smp(13'h0250, 10'h250, 2'd2);
      smp(13'h0300, 10'h300, 2'd2);
      smp(13'h0301, 10'h301, 2'd3);
      smp(13'h1FFF, 10'h3FF, 2'd3);
      compLinear <= 1'b1;
      smp(13'h0A5B, 10'h14B, 2'd0);
      compLinear <= 1'b0;
      @(posedge mclk);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rd(8'h35, 8'hBF);
      rd(8'h3A, 8'h05);
      results();
   end
endmodule // test_compander_segment_params
